// File: pdm_board_model.sv
// Board circuitry model on the eight port pins
`default_nettype none
module pdm_board_model (
   input wire logic clk,             // System clock
   input wire logic [7:0] padOut,    // Device output value
   input wire logic [7:0] padOe,     // Device output enable
   input wire logic [7:0] padPullup, // Device pull-up enable
   input wire logic boardDrive,      // Board drives undriven pins
   input wire logic [7:0] boardVal,  // Level the board drives
   output logic [7:0] padIn          // Resolved pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] floatQ = 8'h5a; // Floating level, flips each cycle
   // A floating pin must never look settled
   always @(posedge clk) begin
      floatQ <= ~floatQ;
   end
   // Device drive wins, then board, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         padIn[i] = padOe[i] ? padOut[i] : boardDrive ? boardVal[i] : padPullup[i] ? 1'b1 : floatQ[i];
      end
   end
endmodule
`default_nettype wire

// File: pdm_defines.svh
// Constants for the port D alternate function override block
// Operation
// - Transmitter enabled forces pin1 output with data
// - Receiver enabled forces pin0 input
// - Pin0 pull-up follows port data, gated
// - Enabled compare output overrides pin value
// - Pin3 input enabled by irq1 or group2
// - Pin2 input enabled by irq0 or group1
// - Pins 0..7 feed pin-change sources 16..23
// - Pins 2,3 feed external irq 0,1
// - Pin4 carries serial sync clock
// - Pin5 feeds timer1, pin4 timer0 count
// - Control register at 0x55, I/O 0x35
// - Global pull-up disable kills all pull-ups
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
// ****************************************
// Register map
// ****************************************
`define PDM_MCU_CONTROL_DATA_ADDR 8'h55
`define PDM_IO_SPACE_OFFSET 8'h20
`define PDM_MCU_CONTROL_IO_ADDR 8'h35
`define PDM_MCU_CONTROL_RESET 8'h00
`define PDM_MCU_CONTROL_WMASK 8'h73
// ****************************************
// Field positions
// ****************************************
`define PDM_BIT_VECTOR_CHANGE_UNLOCK 0
`define PDM_BIT_VECTOR_TABLE_SELECT 1
`define PDM_BIT_GLOBAL_PULLUP_DISABLE 4
`define PDM_BIT_BROWNOUT_SLEEP_OFF_UNLOCK 5
`define PDM_BIT_BROWNOUT_SLEEP_OFF 6
`define PDM_PIN_RX 0
`define PDM_PIN_TX 1
`define PDM_PIN_IRQ0 2
`define PDM_PIN_IRQ1 3
`define PDM_PIN_SYNC_CLOCK 4
`define PDM_PIN_TIMER1_COUNT 5
`define PDM_PIN_CMP0A 6
`endif

// File: pdm_pin_mux.sv
// Single pin override combiner
`default_nettype none
module pdm_pin_mux (
   input wire pdm_pkg::pdm_ovr_t ovr, // Override set for this pin
   input wire logic portData,         // Port data register bit
   input wire logic portDir,          // Direction register bit
   input wire logic pullupDisable,    // Global pull-up disable
   output logic pullupEn,             // Resulting pull-up
   output logic drive,                // Resulting output enable
   output logic value,                // Resulting output value
   output logic inputEnable           // Digital input enable
);
   // Combine overrides with port registers
   always_comb begin
      drive = ovr.ddOvrEn ? ovr.ddOvrVal : portDir;
      value = ovr.pvOvrEn ? ovr.pvOvrVal : portData;
      // Pull-up only for an input with data one, unless disabled
      pullupEn = ovr.puOvrEn ? ovr.puOvrVal : (portData & ~portDir & ~pullupDisable);
      // Sleep gating is outside; here input is always on,
      // whether or not the digital input override asks for it
      inputEnable = 1'b1;
      if (ovr.dieOvrEn) begin
         inputEnable = 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: pdm_pkg.sv
// Types for the port D alternate function override block
`default_nettype none
package pdm_pkg;
   // Per-pin override set
   typedef struct packed {
      logic puOvrEn;   // Pull-up override enable
      logic puOvrVal;  // Pull-up override value
      logic ddOvrEn;   // Direction override enable
      logic ddOvrVal;  // Direction override value
      logic pvOvrEn;   // Output value override enable
      logic pvOvrVal;  // Output value override value
      logic dieOvrEn;  // Digital input enable override
   } pdm_ovr_t;
   // Alternate-function controls from peripherals
   typedef struct packed {
      logic transmitterEnable;
      logic receiverEnable;
      logic txData;
      logic serialModeSelect;
      logic syncClockOut;
      logic cmp0aEnable;
      logic cmp0a;
      logic cmp0bEnable;
      logic cmp0b;
      logic cmp2bEnable;
      logic cmp2b;
      logic extIrq0Enable;
      logic extIrq1Enable;
      logic pinChangeGroup1Enable;
      logic pinChangeGroup2Enable;
   } pdm_alt_t;
   // Inputs handed back to peripherals
   typedef struct packed {
      logic rxData;
      logic syncClockIn;
      logic timerZeroCountInput;
      logic timerOneCountInput;
      logic extIrqZeroInput;
      logic extIrqOneInput;
      logic [7:0] pinChangeSource; // Sources 16..23
   } pdm_din_t;
   // All state of the top module
   typedef struct packed {
      logic [7:0] mcuControl;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] sync3;
      logic [7:0] pinsIn;
      logic [7:0] padOut;
      logic [7:0] padOe;
      logic [7:0] padPullup;
      logic [7:0] readData;
   } pdm_state_t;
endpackage
`default_nettype wire

// File: pdm_port_d.sv
// Port D alternate function override with control register
`include "pdm_defines.svh"
`default_nettype none
module pdm_port_d (
   input wire logic clk,                    // 40 MHz system clock
   input wire logic sys_rst,                // Synchronous reset, high
   input wire logic [7:0] ioAddr,           // Data-space or I/O address
   input wire logic ioSpace,                // High for I/O instruction access
   input wire logic wrEn,                   // Register write strobe
   input wire logic rdEn,                   // Register read strobe
   input wire logic [7:0] wrData,           // Write data
   output logic [7:0] rdData,               // Registered read data
   input wire logic [7:0] portData,         // Port data register
   input wire logic [7:0] portDir,          // Direction register
   input wire pdm_pkg::pdm_alt_t alt,       // Peripheral controls
   output var pdm_pkg::pdm_din_t din,       // Peripheral inputs
   input wire logic [7:0] padIn,            // Pad input levels
   output logic [7:0] padOut,               // Pad output value
   output logic [7:0] padOe,                // Pad output enable
   output logic [7:0] padPullup,            // Pad pull-up enable
   output logic [7:0] padInputEnable,       // Digital input enables
   output logic globalPullupDisable         // Pull-up disable bit
);
   // ****************************************
   // State and override computation
   // ****************************************
   pdm_pkg::pdm_state_t stateQ; // Registered state
   pdm_pkg::pdm_state_t stateD; // Next state
   pdm_pkg::pdm_ovr_t ovr [8];  // Overrides per pin
   logic [7:0] pullupW;          // Combined pull-ups
   logic [7:0] driveW;           // Combined directions
   logic [7:0] valueW;           // Combined values
   logic pullupOff;              // Pull-up disable

   // Address decode shared by read and write paths
   function automatic logic hitControl(input logic [7:0] a, input logic io);
      hitControl = io ? (a == `PDM_MCU_CONTROL_IO_ADDR) : (a == `PDM_MCU_CONTROL_DATA_ADDR);
   endfunction

   assign pullupOff = stateQ.mcuControl[`PDM_BIT_GLOBAL_PULLUP_DISABLE];

   // Fill override sets from peripheral controls
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ovr[i] = '0;
      end
      // Receive pin forced input, pull-up from port data
      ovr[0].puOvrEn = alt.receiverEnable;
      ovr[0].puOvrVal = portData[0] & ~pullupOff;
      ovr[0].ddOvrEn = alt.receiverEnable;
      ovr[0].ddOvrVal = 1'b0;
      ovr[0].dieOvrEn = alt.pinChangeGroup2Enable & portData[0];
      // Transmit pin forced output carrying data
      ovr[1].puOvrEn = alt.transmitterEnable;
      ovr[1].ddOvrEn = alt.transmitterEnable;
      ovr[1].ddOvrVal = 1'b1;
      ovr[1].pvOvrEn = alt.transmitterEnable;
      ovr[1].pvOvrVal = alt.txData;
      ovr[2].dieOvrEn = alt.extIrq0Enable | alt.pinChangeGroup1Enable;
      // Timer2 B output; direction is left to software
      ovr[3].pvOvrEn = alt.cmp2bEnable;
      ovr[3].pvOvrVal = alt.cmp2b;
      ovr[3].dieOvrEn = alt.extIrq1Enable | alt.pinChangeGroup2Enable;
      ovr[4].pvOvrEn = alt.serialModeSelect;
      ovr[4].pvOvrVal = alt.syncClockOut;
      ovr[5].pvOvrEn = alt.cmp0bEnable;
      ovr[5].pvOvrVal = alt.cmp0b;
      ovr[6].pvOvrEn = alt.cmp0aEnable;
      ovr[6].pvOvrVal = alt.cmp0a;
      // Pins 7 and 6 as comparator inputs rely on software setup
   end

   // ****************************************
   // Per-pin combiners
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gPin
         pdm_pin_mux uMux (
            .ovr(ovr[g]),
            .portData(portData[g]),
            .portDir(portDir[g]),
            .pullupDisable(pullupOff),
            .pullupEn(pullupW[g]),
            .drive(driveW[g]),
            .value(valueW[g]),
            .inputEnable(padInputEnable[g])
         );
      end
   endgenerate

   // Next-state logic: register, synchroniser, pad registers
   always_comb begin
      stateD = stateQ;
      stateD.sync1 = padIn;
      stateD.sync2 = stateQ.sync1;
      stateD.sync3 = stateQ.sync2;
      // Accept a change only when second and third stages agree
      for (int i = 0; i < 8; i++) begin
         if (stateQ.sync2[i] == stateQ.sync3[i]) begin
            stateD.pinsIn[i] = stateQ.sync3[i];
         end
      end
      if (wrEn && hitControl(ioAddr, ioSpace)) begin
         stateD.mcuControl = wrData & `PDM_MCU_CONTROL_WMASK;
      end
      if (rdEn) begin
         stateD.readData = hitControl(ioAddr, ioSpace) ? stateQ.mcuControl : 8'h00;
      end
      stateD.padOut = valueW;
      stateD.padOe = driveW;
      stateD.padPullup = pullupW & ~{8{pullupOff}};
      if (sys_rst) begin
         stateD = '0;
         stateD.mcuControl = `PDM_MCU_CONTROL_RESET;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      stateQ <= stateD;
   end

   // ****************************************
   // Outputs and routing of pin inputs
   // ****************************************
   assign rdData = stateQ.readData;
   assign padOut = stateQ.padOut;
   assign padOe = stateQ.padOe;
   assign padPullup = stateQ.padPullup;
   assign globalPullupDisable = pullupOff;
   assign din.pinChangeSource = stateQ.pinsIn;
   assign din.rxData = stateQ.pinsIn[`PDM_PIN_RX];
   assign din.syncClockIn = stateQ.pinsIn[`PDM_PIN_SYNC_CLOCK];
   assign din.timerZeroCountInput = stateQ.pinsIn[`PDM_PIN_SYNC_CLOCK];
   assign din.timerOneCountInput = stateQ.pinsIn[`PDM_PIN_TIMER1_COUNT];
   assign din.extIrqZeroInput = stateQ.pinsIn[`PDM_PIN_IRQ0];
   assign din.extIrqOneInput = stateQ.pinsIn[`PDM_PIN_IRQ1];

   // ****************************************
   // Assertions
   // ****************************************
   // Serial pins
   tx_force_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.transmitterEnable |=> padOe[`PDM_PIN_TX])
      else $error("tx pin not driven");
   tx_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.transmitterEnable |=> padOut[`PDM_PIN_TX] == $past(alt.txData))
      else $error("tx data not on pin");
   tx_pullup_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.transmitterEnable |=> !padPullup[`PDM_PIN_TX])
      else $error("tx pin pull-up on");
   rx_force_in_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.receiverEnable |=> !padOe[`PDM_PIN_RX])
      else $error("rx pin driven");
   rx_pullup_a: assert property (@(posedge clk) disable iff (sys_rst)
      (alt.receiverEnable && portData[0] && !pullupOff) |=> padPullup[0])
      else $error("rx pull-up missing");

   // Compare outputs and serial clock
   cmp0a_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.cmp0aEnable |=> padOut[`PDM_PIN_CMP0A] == $past(alt.cmp0a))
      else $error("compare A not on pin");
   cmp0b_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.cmp0bEnable |=> padOut[5] == $past(alt.cmp0b))
      else $error("compare B not on pin");
   cmp2b_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.cmp2bEnable |=> padOut[3] == $past(alt.cmp2b))
      else $error("timer2 compare not on pin");
   sync_clock_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.serialModeSelect |=> padOut[4] == $past(alt.syncClockOut))
      else $error("sync clock not on pin");

   // Pull-ups and port register defaults
   pullup_kill_a: assert property (@(posedge clk) disable iff (sys_rst)
      pullupOff |=> padPullup == 8'h00)
      else $error("pull-up on while disabled");
   default_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!alt.transmitterEnable && !alt.receiverEnable) |=> padOe[1:0] == $past(portDir[1:0]))
      else $error("port direction not followed");
   default_pullup_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!alt.transmitterEnable && !alt.receiverEnable) |=>
      padPullup[1:0] == ($past(portData[1:0]) & ~$past(portDir[1:0]) & ~{2{$past(pullupOff)}}))
      else $error("port pull-up not followed");
   pin6_default_a: assert property (@(posedge clk) disable iff (sys_rst)
      !alt.cmp0aEnable |=> padOut[6] == $past(portData[6]))
      else $error("port value not followed");

   // Control register decode; reserved bits must stay zero for software
   io_alias_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrEn && ioSpace && ioAddr == 8'h35) |=> stateQ.mcuControl == ($past(wrData) & 8'h73))
      else $error("io write lost");
   data_alias_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrEn && !ioSpace && ioAddr == 8'h55) |=> stateQ.mcuControl == ($past(wrData) & 8'h73))
      else $error("data space write lost");
   read_miss_a: assert property (@(posedge clk) disable iff (sys_rst)
      (rdEn && !hitControl(ioAddr, ioSpace)) |=> rdData == 8'h00)
      else $error("read of other address not zero");
   write_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      (stateQ.mcuControl & 8'h8c) == 8'h00)
      else $error("reserved control bit set");

   // Routing of synchronised inputs; a pin still settling must not leak through
   pin_change_a: assert property (@(posedge clk) disable iff (sys_rst)
      (stateQ.sync2 == stateQ.sync3) |=> din.pinChangeSource == $past(stateQ.sync3))
      else $error("pin change source not settled value");
   rx_route_a: assert property (@(posedge clk) disable iff (sys_rst)
      (din.rxData == din.pinChangeSource[0]) && (din.syncClockIn == din.pinChangeSource[4]))
      else $error("serial input routing wrong");
   ext_irq_route_a: assert property (@(posedge clk) disable iff (sys_rst)
      {din.extIrqOneInput, din.extIrqZeroInput} == din.pinChangeSource[3:2])
      else $error("external irq routing wrong");
   count_route_a: assert property (@(posedge clk) disable iff (sys_rst)
      {din.timerOneCountInput, din.timerZeroCountInput} == din.pinChangeSource[5:4])
      else $error("count input routing wrong");
   pin3_die_a: assert property (@(posedge clk) disable iff (sys_rst)
      alt.extIrq1Enable |-> padInputEnable[3])
      else $error("pin3 input disabled");
   pin2_die_a: assert property (@(posedge clk) disable iff (sys_rst)
      (alt.extIrq0Enable || alt.pinChangeGroup1Enable) |-> padInputEnable[2])
      else $error("pin2 input disabled");
endmodule
`default_nettype wire

// File: port_d_alt_function_override_tb.sv
// Self-checking bench for the port D override block
`default_nettype none
module port_d_alt_function_override_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0; // 40 MHz clock
   logic sys_rst = 1'b1; // Held 8 cycles
   logic ioSpace = 1'b0, wrEn = 1'b0, rdEn = 1'b0, boardDrive = 1'b0, pullupOff = 1'b0;
   logic [7:0] ioAddr = 8'h00, wrData = 8'h00, portData = 8'h00, portDir = 8'h00, boardVal = 8'h00;
   logic [7:0] rdData, padOut, padOe, padPullup, padInputEnable, padIn, pd, dd;
   logic [7:0] lfsr = 8'h44; // Random source
   logic globalPullupDisable;
   pdm_pkg::pdm_alt_t alt = '0, a;
   pdm_pkg::pdm_din_t din;
   int failures = 0, check_count = 0;
   always #12.5 clk = ~clk;
   pdm_port_d pdm_port_d_i (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr), .ioSpace(ioSpace),
      .wrEn(wrEn), .rdEn(rdEn), .wrData(wrData), .rdData(rdData), .portData(portData),
      .portDir(portDir), .alt(alt), .din(din), .padIn(padIn), .padOut(padOut), .padOe(padOe),
      .padPullup(padPullup), .padInputEnable(padInputEnable), .globalPullupDisable(globalPullupDisable));
   pdm_board_model pdm_board_model_i (.clk(clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
      .boardDrive(boardDrive), .boardVal(boardVal), .padIn(padIn));
   // ****
   // Helpers
   // ****
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Expected {visible value, enable, pull-up}
   function automatic logic [23:0] expPads(input logic [7:0] d, input logic [7:0] r,
      input pdm_pkg::pdm_alt_t c, input logic u);
      logic [7:0] o, e, p;
      o = d;
      e = r;
      p = d & ~r & {8{~u}};
      if (c.transmitterEnable) begin
         e[1] = 1'b1;
         o[1] = c.txData;
         p[1] = 1'b0;
      end
      if (c.receiverEnable) begin
         e[0] = 1'b0;
         p[0] = d[0] & ~u;
      end
      if (c.cmp0aEnable) o[6] = c.cmp0a;
      if (c.cmp0bEnable) o[5] = c.cmp0b;
      if (c.cmp2bEnable) o[3] = c.cmp2b;
      if (c.serialModeSelect) o[4] = c.syncClockOut;
      return {o & e, e, p};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic reg_wr(input logic io, input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      ioSpace <= io;
      ioAddr <= ad;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask
   task automatic reg_rd(input logic io, input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk);
      ioSpace <= io;
      ioAddr <= ad;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1;
      chk(rdData, exp);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      wait_clk(8);
      sys_rst <= 1'b0;
      wait_clk(1);
      #1;
      chk({rdData, padOut, padOe, padPullup}, 32'h0);
      reg_rd(1'b1, 8'h35, 8'h00);
      // Both address spaces, plus near misses that must be ignored
      for (int i = 0; i < 8; i++) begin
         lfsr = nxt(lfsr);
         reg_wr(i[0], i[0] ? 8'h35 : 8'h55, lfsr);
         reg_wr(i[0], i[0] ? 8'h34 : 8'h56, ~lfsr);
         reg_rd(~i[0], i[0] ? 8'h55 : 8'h35, lfsr & 8'h73);
         reg_rd(i[0], i[0] ? 8'h34 : 8'h56, 8'h00);
      end
      pullupOff = lfsr[4];
      // Random overrides; first pass is all pull-ups wanted and enabled
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         pd = nxt(lfsr);
         dd = nxt(pd);
         lfsr = nxt(dd);
         a = pdm_pkg::pdm_alt_t'({dd[6:0], lfsr});
         if (i == 0) begin
            pd = 8'hff;
            dd = 8'h00;
            a = '0;
         end
         dd[6] = dd[6] | a.cmp0aEnable;
         dd[5] = dd[5] | a.cmp0bEnable;
         dd[3] = dd[3] | a.cmp2bEnable;
         portData <= pd;
         portDir <= dd;
         alt <= a;
         if (i % 8 == 0) begin
            pullupOff = ~pullupOff;
            reg_wr(1'b0, 8'h55, {3'h0, pullupOff, 4'h0});
         end
         wait_clk(2);
         #1;
         chk({padOut & padOe, padOe, padPullup}, expPads(pd, dd, a, pullupOff));
         chk(globalPullupDisable, pullupOff);
         chk(padInputEnable, 8'hff);
      end
      // Board drives every pin, device lets go
      @(posedge clk);
      alt <= '0;
      portDir <= 8'h00;
      portData <= 8'h00;
      boardDrive <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk);
         lfsr = nxt(lfsr);
         boardVal <= lfsr;
         wait_clk(6);
         #1;
         chk(din, {lfsr[0], lfsr[4], lfsr[4], lfsr[5], lfsr[2], lfsr[3], lfsr});
      end
      // Reset in mid-run clears the control register
      reg_wr(1'b1, 8'h35, 8'h73);
      @(posedge clk);
      sys_rst <= 1'b1;
      wait_clk(2);
      sys_rst <= 1'b0;
      reg_rd(1'b0, 8'h55, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
